// file: design/esa_sa_si_access.sv
`default_nettype none
module esa_sa_si_access
  import esa_pkg::*;
#(
  parameter logic FRAMER_SEL = 1'b0
)
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // host register port
  input  wire esa_req_t   host_req,
  output logic      [7:0] host_rdata,
  output logic            host_ack,
  // receive side from framer
  input  wire logic       rx_frame_strobe,
  input  wire logic       rx_nonalign,
  input  wire logic [2:0] rx_frame_idx,
  input  wire esa_bits_t  rx_bits,
  input  wire logic       rx_smf_strobe,
  input  wire logic       rx_mf_strobe,
  // transmit side to framer
  input  wire logic       tx_mf_strobe,
  input  wire logic       tx_frame_strobe,
  input  wire logic       tx_nonalign,
  input  wire logic [2:0] tx_frame_idx,
  input  wire esa_bits_t  tx_default,
  output esa_bits_t       tx_bits,
  output logic            interrupt_out_n
);
  localparam logic [9:0] BASE = FRAMER_SEL ? ESA_FRAMER2 : 10'h000;

  // two Si, remote alarm and Sa4..Sa8 slots need exactly eight registers
  if (ESA_NREG != 8) begin : g_nreg_check
    $error("eight spare registers expected");
  end

  logic [7:0] rx_work_r   [ESA_NREG];
  logic [7:0] rx_work_nxt [ESA_NREG];
  logic [7:0] rx_hold_r   [ESA_NREG];
  logic [7:0] rx_hold_nxt [ESA_NREG];
  logic [7:0] tx_host_r   [ESA_NREG];
  logic [7:0] tx_host_nxt [ESA_NREG];
  logic [7:0] tx_live_r   [ESA_NREG];
  logic [7:0] tx_live_nxt [ESA_NREG];
  logic [7:0] stat2_r;
  logic [7:0] stat2_nxt;
  logic [7:0] stat7_r;
  logic [7:0] stat7_nxt;
  logic [7:0] tstat1_r;
  logic [7:0] tstat1_nxt;
  logic [7:0] mask7_r;
  logic [7:0] mask7_nxt;
  logic [7:0] monsel_r;
  logic [7:0] monsel_nxt;
  logic [7:0] srcctl_r;
  logic [7:0] srcctl_nxt;
  logic [4:0] sa_cur_r;
  logic [4:0] sa_cur_nxt;
  logic       sa_seen_r;
  logic       sa_seen_nxt;
  logic [3:0] s6_acc_r;
  logic [3:0] s6_acc_nxt;
  logic [7:0] rdata_nxt;
  logic       ack_nxt;
  logic       irq_n_nxt;
  logic [3:0] s6_code;
  logic       s6_changed;
  logic       sa_change;
  logic [7:0] w1c;
  esa_bits_t  tx_bits_nxt;
  logic [9:0] off;

  // ******************************************
  // helpers
  // ******************************************
  function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
    return a == r;
  endfunction

  function automatic logic in8(input logic [9:0] a, input logic [9:0] b);
    return (a >= b) && (a < b + 10'(ESA_NREG));
  endfunction

  function automatic logic [2:0] idx8(input logic [9:0] a,
                                      input logic [9:0] b);
    return 3'(a - b);
  endfunction

  esa_sa6_detect u_sa6 (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .smf_strobe (rx_smf_strobe),
    .smf_code   (s6_acc_nxt),
    .code_r     (s6_code),
    .changed    (s6_changed)
  );

  assign off = host_req.addr - BASE;

  // ******************************************
  // receive capture
  // ******************************************
  always_comb begin
    for (int i = 0; i < ESA_NREG; i++) begin
      rx_work_nxt[i] = rx_work_r[i];
      rx_hold_nxt[i] = rx_hold_r[i];
    end
    sa_cur_nxt  = sa_cur_r;
    sa_seen_nxt = sa_seen_r;
    s6_acc_nxt  = s6_acc_r;
    sa_change   = 1'b0;
    if (rx_frame_strobe) begin
      if (!rx_nonalign) begin
        rx_work_nxt[ESA_REG_SIAF][rx_frame_idx] = rx_bits.si;
      end else begin
        rx_work_nxt[ESA_REG_SINAF][rx_frame_idx] = rx_bits.si;
        rx_work_nxt[ESA_REG_RA][rx_frame_idx]    = rx_bits.ra;
        for (int k = 0; k < 5; k++)
          rx_work_nxt[ESA_REG_SA4 + k][rx_frame_idx] = rx_bits.sa[k];
        sa_cur_nxt  = rx_bits.sa;
        sa_seen_nxt = 1'b1;
        s6_acc_nxt[rx_frame_idx[1:0]] = rx_bits.sa[ESA_SA6_POS];
        sa_change = sa_seen_r &&
                    (((rx_bits.sa ^ sa_cur_r) & monsel_r[4:0]) != 5'h00);
      end
    end
    if (rx_mf_strobe) begin
      for (int i = 0; i < ESA_NREG; i++)
        rx_hold_nxt[i] = rx_work_nxt[i];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < ESA_NREG; i++) begin
        rx_work_r[i] <= ESA_ZERO8;
        rx_hold_r[i] <= ESA_ZERO8;
      end
      sa_cur_r  <= 5'h00;
      sa_seen_r <= 1'b0;
      s6_acc_r  <= ESA_ZERO4;
    end else begin
      for (int i = 0; i < ESA_NREG; i++) begin
        rx_work_r[i] <= rx_work_nxt[i];
        rx_hold_r[i] <= rx_hold_nxt[i];
      end
      sa_cur_r  <= sa_cur_nxt;
      sa_seen_r <= sa_seen_nxt;
      s6_acc_r  <= s6_acc_nxt;
    end
  end

  // ******************************************
  // host settings and transmit sampling
  // ******************************************
  always_comb begin
    mask7_nxt  = mask7_r;
    monsel_nxt = monsel_r;
    srcctl_nxt = srcctl_r;
    for (int i = 0; i < ESA_NREG; i++) begin
      tx_host_nxt[i] = tx_host_r[i];
      tx_live_nxt[i] = tx_live_r[i];
    end
    if (host_req.wr) begin
      if (hit(off, ESA_RX_MASK7))
        mask7_nxt = host_req.wdata;
      if (hit(off, ESA_MON_SEL))
        monsel_nxt = host_req.wdata;
      if (hit(off, ESA_TX_SRC))
        srcctl_nxt = host_req.wdata;
      if (in8(off, ESA_TX_SIAF))
        tx_host_nxt[idx8(off, ESA_TX_SIAF)] = host_req.wdata;
    end
    if (tx_mf_strobe) begin
      for (int i = 0; i < ESA_NREG; i++)
        tx_live_nxt[i] = tx_host_r[i];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < ESA_NREG; i++) begin
        tx_host_r[i] <= ESA_ZERO8;
        tx_live_r[i] <= ESA_ZERO8;
      end
      mask7_r  <= ESA_ZERO8;
      monsel_r <= ESA_ZERO8;
      srcctl_r <= ESA_ZERO8;
    end else begin
      for (int i = 0; i < ESA_NREG; i++) begin
        tx_host_r[i] <= tx_host_nxt[i];
        tx_live_r[i] <= tx_live_nxt[i];
      end
      mask7_r  <= mask7_nxt;
      monsel_r <= monsel_nxt;
      srcctl_r <= srcctl_nxt;
    end
  end

  // ******************************************
  // latched status and interrupt
  // ******************************************
  always_comb begin
    w1c = host_req.wr ? host_req.wdata : ESA_ZERO8;
    // write one clears; sets below win
    stat2_nxt  = stat2_r & ~(hit(off, ESA_RX_STAT2) ? w1c : ESA_ZERO8);
    stat7_nxt  = stat7_r & ~(hit(off, ESA_RX_STAT7) ? w1c : ESA_ZERO8);
    tstat1_nxt = tstat1_r & ~(hit(off, ESA_TX_STAT1) ? w1c : ESA_ZERO8);
    if (rx_mf_strobe)
      stat2_nxt[ESA_STAT2_MF] = 1'b1;
    if (sa_change)
      stat7_nxt[ESA_STAT7_SA] = 1'b1;
    if (s6_changed)
      stat7_nxt[ESA_STAT7_S6] = 1'b1;
    if (tx_mf_strobe)
      tstat1_nxt[ESA_STAT1_MF] = 1'b1;
    irq_n_nxt = ((stat7_nxt & mask7_r) == ESA_ZERO8);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stat2_r         <= ESA_ZERO8;
      stat7_r         <= ESA_ZERO8;
      tstat1_r        <= ESA_ZERO8;
      interrupt_out_n <= 1'b1;
    end else begin
      stat2_r         <= stat2_nxt;
      stat7_r         <= stat7_nxt;
      tstat1_r        <= tstat1_nxt;
      interrupt_out_n <= irq_n_nxt;
    end
  end

  // ******************************************
  // transmit insertion
  // ******************************************
  always_comb begin
    tx_bits_nxt = tx_bits;
    if (tx_frame_strobe) begin
      tx_bits_nxt = tx_default;
      if (!tx_nonalign) begin
        if (srcctl_r[ESA_SRC_SIAF])
          tx_bits_nxt.si = tx_live_r[ESA_REG_SIAF][tx_frame_idx];
      end else begin
        if (srcctl_r[ESA_SRC_SINAF])
          tx_bits_nxt.si = tx_live_r[ESA_REG_SINAF][tx_frame_idx];
        if (srcctl_r[ESA_SRC_RA])
          tx_bits_nxt.ra = tx_live_r[ESA_REG_RA][tx_frame_idx];
        for (int k = 0; k < 5; k++)
          if (srcctl_r[ESA_SRC_SA4 - k])
            tx_bits_nxt.sa[k] = tx_live_r[ESA_REG_SA4 + k][tx_frame_idx];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      tx_bits <= '0;
    else
      tx_bits <= tx_bits_nxt;
  end

  // ******************************************
  // host read path
  // ******************************************
  always_comb begin
    ack_nxt   = host_req.rd | host_req.wr;
    rdata_nxt = ESA_ZERO8;
    if (host_req.rd) begin
      if (in8(off, ESA_RX_SIAF))
        rdata_nxt = rx_hold_r[idx8(off, ESA_RX_SIAF)];
      else if (in8(off, ESA_TX_SIAF))
        rdata_nxt = tx_host_r[idx8(off, ESA_TX_SIAF)];
      else if (hit(off, ESA_SA_LIVE))
        rdata_nxt = {3'b000, sa_cur_r};
      else if (hit(off, ESA_S6_WORD))
        rdata_nxt = {ESA_ZERO4, s6_code};
      else if (hit(off, ESA_RX_STAT2))
        rdata_nxt = stat2_r;
      else if (hit(off, ESA_RX_STAT7))
        rdata_nxt = stat7_r;
      else if (hit(off, ESA_TX_STAT1))
        rdata_nxt = tstat1_r;
      else if (hit(off, ESA_RX_MASK7))
        rdata_nxt = mask7_r;
      else if (hit(off, ESA_MON_SEL))
        rdata_nxt = monsel_r;
      else if (hit(off, ESA_TX_SRC))
        rdata_nxt = srcctl_r;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      host_rdata <= ESA_ZERO8;
      host_ack   <= 1'b0;
    end else begin
      host_rdata <= rdata_nxt;
      host_ack   <= ack_nxt;
    end
  end
endmodule
`default_nettype wire

// file: include/esa_pkg.sv
// What this block does
// - eight receive registers hold Si, remote alarm and Sa4..Sa8 bits
// - receive registers update when the receive multiframe flag sets
// - transmit Si/Sa bits come from eight host registers per source control
// - transmit registers sampled when the transmit multiframe flag sets
// - host rewrites within 2 ms, else previous values are sent again
// - only Sa positions enabled in the monitor select are watched
// - any enabled Sa change sets status seven bit 0
// - Sa change interrupt only when mask seven bit 0 unmasks it
// - read-only register at 06Eh gives the current Sa bits
// - received Sa6 codeword readable in its own register
// - Sa6 codeword stored only after three equal submultiframes and new
// - stored Sa6 codeword update sets a latched status seven bit
// - Sa6 change interrupt gated by its mask seven bit
// - latched bits clear on write 1, write 0 leaves them
// - active-low interrupt low while any unmasked latched status seven bit set
// - second framer registers sit at first framer offsets plus 200h
`default_nettype none
package esa_pkg;
  localparam int          ESA_AW        = 10;
  localparam logic [9:0]  ESA_FRAMER2   = 10'h200;
  localparam logic [9:0]  ESA_RX_SIAF   = 10'h066;
  localparam logic [9:0]  ESA_RX_SINAF  = 10'h067;
  localparam logic [9:0]  ESA_RX_RA     = 10'h068;
  localparam logic [9:0]  ESA_RX_SA4    = 10'h069;
  localparam logic [9:0]  ESA_SA_LIVE   = 10'h06e;
  localparam logic [9:0]  ESA_S6_WORD   = 10'h06f;
  localparam logic [9:0]  ESA_RX_STAT2  = 10'h091;
  localparam logic [9:0]  ESA_RX_STAT7  = 10'h096;
  localparam logic [9:0]  ESA_RX_MASK7  = 10'h0a6;
  localparam logic [9:0]  ESA_MON_SEL   = 10'h0a7;
  localparam logic [9:0]  ESA_TX_SRC    = 10'h114;
  localparam logic [9:0]  ESA_TX_SIAF   = 10'h166;
  localparam logic [9:0]  ESA_TX_STAT1  = 10'h190;
  localparam int          ESA_NREG      = 8;
  localparam int          ESA_STAT2_MF  = 1;
  localparam int          ESA_STAT1_MF  = 3;
  localparam int          ESA_STAT7_SA  = 0;
  localparam int          ESA_STAT7_S6  = 1;
  localparam int          ESA_S6_STABLE = 3;
  // spare register slots and their source-control bits
  localparam int          ESA_REG_SIAF  = 0;
  localparam int          ESA_REG_SINAF = 1;
  localparam int          ESA_REG_RA    = 2;
  localparam int          ESA_REG_SA4   = 3;
  localparam int          ESA_SRC_SIAF  = 7;
  localparam int          ESA_SRC_SINAF = 6;
  localparam int          ESA_SRC_RA    = 5;
  localparam int          ESA_SRC_SA4   = 4;
  localparam int          ESA_SA6_POS   = 2;
  localparam logic [7:0]  ESA_ZERO8     = 8'h00;
  localparam logic [3:0]  ESA_ZERO4     = 4'h0;
  // one frame of line-side spare bits (Sa4..Sa8 in [4:0])
  typedef struct packed {
    logic       si;
    logic       ra;
    logic [4:0] sa;
  } esa_bits_t;
  // host register port
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [9:0] addr;
    logic [7:0] wdata;
  } esa_req_t;
endpackage
`default_nettype wire

// file: design/esa_sa6_detect.sv
`default_nettype none
module esa_sa6_detect
  import esa_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       smf_strobe,
  input  wire logic [3:0] smf_code,
  output logic      [3:0] code_r,
  output logic            changed
);
  logic [3:0] cand_r;
  logic [3:0] cand_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic [3:0] code_nxt;

  // ******************************************
  // stability filter
  // ******************************************
  always_comb begin
    cand_nxt = cand_r;
    cnt_nxt  = cnt_r;
    code_nxt = code_r;
    changed  = 1'b0;
    if (smf_strobe) begin
      cand_nxt = smf_code;
      if (smf_code != cand_r)
        cnt_nxt = 2'd1;
      else if (cnt_r != 2'(ESA_S6_STABLE))
        cnt_nxt = cnt_r + 2'd1;
      if ((smf_code == cand_r) && (cnt_r == 2'(ESA_S6_STABLE - 1)) &&
          (smf_code != code_r)) begin
        code_nxt = smf_code;
        changed  = 1'b1;
      end else if ((smf_code == cand_r) &&
                   (cnt_r == 2'(ESA_S6_STABLE)) &&
                   (smf_code != code_r)) begin
        code_nxt = smf_code;
        changed  = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cand_r <= ESA_ZERO4;
      cnt_r  <= 2'd0;
      code_r <= ESA_ZERO4;
    end else begin
      cand_r <= cand_nxt;
      cnt_r  <= cnt_nxt;
      code_r <= code_nxt;
    end
  end
endmodule
`default_nettype wire

// file: tb/esa_checker.sv
`default_nettype none
module esa_checker
  import esa_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire esa_req_t   host_req,
  input wire logic [7:0] host_rdata,
  input wire logic       host_ack,
  input wire logic       rx_mf_strobe,
  input wire logic       tx_frame_strobe,
  input wire esa_bits_t  tx_bits,
  input wire logic       interrupt_out_n
);
  timeunit 1ns;
  timeprecision 100ps;
  wire       rq = host_req.rd | host_req.wr;
  wire       rd = host_req.rd;
  wire [9:0] ad = host_req.addr;
  wire       wm = host_req.wr && ad == ESA_RX_MASK7;
  wire       nm = !rx_mf_strobe;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ****
  // host port, status and transmit checks
  // ****
  ack_on_req_a: assert property (rq |=> host_ack)
    else $error("no ack after request");
  ack_idle_a: assert property (!rq |=> !host_ack)
    else $error("ack without request");
  ack_burst_a: assert property (rq ##1 rq |-> host_ack [*2])
    else $error("back to back ack lost");
  far_framer_a: assert property (
    rd && ad == (ESA_FRAMER2 | ESA_RX_STAT7) |=> host_rdata == ESA_ZERO8)
    else $error("second framer answered");
  mask_gate_a: assert property (wm && host_req.wdata == ESA_ZERO8
    ##1 !wm |=> interrupt_out_n) else $error("masked interrupt seen");
  mask_back_a: assert property (wm ##1 !wm ##1 rd && ad == ESA_RX_MASK7
    |=> host_rdata == $past(host_req.wdata, 3)) else $error("mask readback");
  tx_hold_a: assert property (!tx_frame_strobe |=> $stable(tx_bits))
    else $error("transmit bits moved between frames");
  flag_clear_a: assert property (nm ##1
    (host_req.wr && ad == ESA_RX_STAT2 && host_req.wdata[1] && nm) ##1 nm
    ##1 (rd && ad == ESA_RX_STAT2 && nm) |=> !host_rdata[1])
    else $error("flag not cleared by write one");
  cover property (rd && ad == ESA_S6_WORD);
  cover property ($fell(interrupt_out_n));
  cover property (tx_frame_strobe ##1 $changed(tx_bits));
endmodule
bind esa_sa_si_access esa_checker i_esa_checker (.ref_clk(ref_clk),
  .rst(rst), .host_req(host_req), .host_rdata(host_rdata),
  .host_ack(host_ack), .rx_mf_strobe(rx_mf_strobe),
  .tx_frame_strobe(tx_frame_strobe), .tx_bits(tx_bits),
  .interrupt_out_n(interrupt_out_n));
`default_nettype wire

// file: tb/esa_line_model.sv
`default_nettype none
module esa_line_model
  import esa_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      rst,
  input  wire esa_bits_t line_bits,
  output logic           frame_stb,
  output logic           nonalign,
  output logic [2:0]     idx,
  output esa_bits_t      bits,
  output logic           smf_stb,
  output logic           mf_stb
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // framing: 4 cycles a frame, 16 frames a multiframe
  // ****
  logic [5:0] cnt_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) cnt_r <= 6'h00;
    else cnt_r <= cnt_r + 6'h01;
  end
  assign frame_stb = cnt_r[1:0] == 2'h0;
  assign nonalign  = cnt_r[2];
  assign idx       = cnt_r[5:3];
  // after the fourth non-align frame of each half
  assign smf_stb   = cnt_r[4:0] == 5'h1d;
  assign mf_stb    = cnt_r == 6'h3e;
  // garbage outside the strobe so stale data is never trusted
  assign bits      = frame_stb ? line_bits : ~line_bits;
endmodule
`default_nettype wire

// file: tb/tb.sv
`default_nettype none
module tb
  import esa_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    err_count++; $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
  logic       ref_clk, rst, ack, irq_n, fs, na, sm, mf;
  logic [2:0] ix;
  logic [7:0] rdata;
  esa_req_t   req;
  esa_bits_t  line_bits, dflt, rb, txb;
  int         err_count, total_checks;
  logic [7:0] rx_exp [8] = '{8'hff, 8'hff, 8'h00, 8'hff,
                             8'h00, 8'hff, 8'h00, 8'hff};
  esa_line_model i_esa_line_model (.ref_clk(ref_clk), .rst(rst),
    .line_bits(line_bits), .frame_stb(fs), .nonalign(na), .idx(ix),
    .bits(rb), .smf_stb(sm), .mf_stb(mf));
  esa_sa_si_access i_esa_sa_si_access (.ref_clk(ref_clk), .rst(rst),
    .host_req(req), .host_rdata(rdata), .host_ack(ack),
    .rx_frame_strobe(fs), .rx_nonalign(na), .rx_frame_idx(ix),
    .rx_bits(rb), .rx_smf_strobe(sm), .rx_mf_strobe(mf),
    .tx_mf_strobe(mf), .tx_frame_strobe(fs), .tx_nonalign(na),
    .tx_frame_idx(ix), .tx_default(dflt), .tx_bits(txb),
    .interrupt_out_n(irq_n));
  // ****
  // access and wait tasks
  // ****
  task automatic acc(input logic w, input logic [9:0] a,
                     input logic [7:0] d, input logic [7:0] e);
    req <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge ref_clk);
    req <= '0;
    #1;
    `CHK(ack, 1'b1)
    if (!w) `CHK(rdata, e)
    @(posedge ref_clk);
  endtask
  task automatic mfw;
    @(posedge ref_clk iff mf);
    repeat (2) @(posedge ref_clk);
  endtask
  // lands just after the first non-align frame of the multiframe
  task automatic txchk(input logic [6:0] e);
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK({txb.si, txb.ra, txb.sa}, e)
    @(posedge ref_clk);
  endtask
  task automatic ichk(input logic e);
    #1;
    `CHK(irq_n, e)
    @(posedge ref_clk);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    conclude();
  end
  // ****
  // main sequence
  // ****
  initial begin
    rst = 1'b1;
    req = '0;
    line_bits = '{si: 1'b1, ra: 1'b0, sa: 5'h15};
    dflt = '{si: 1'b0, ra: 1'b0, sa: 5'h11};
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    ichk(1'b1);
    acc(1'b1, ESA_RX_MASK7, 8'h02, 8'h00);
    req <= '{rd: 1'b1, wr: 1'b0, addr: ESA_RX_MASK7, wdata: 8'h00};
    @(posedge ref_clk);
    acc(1'b0, ESA_RX_MASK7, 8'h00, 8'h02);
    acc(1'b0, ESA_FRAMER2 | ESA_RX_STAT7, 8'h00, 8'h00);
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, ESA_TX_SIAF + 10'(i), (i % 2) ? 8'h00 : 8'hff, 8'h00);
      acc(1'b0, ESA_TX_SIAF + 10'(i), 8'h00, (i % 2) ? 8'h00 : 8'hff);
    end
    acc(1'b1, ESA_TX_SRC, 8'hff, 8'h00);
    mfw();
    txchk(7'h2a);
    acc(1'b0, ESA_RX_STAT2, 8'h00, 8'h02);
    for (int i = 0; i < 8; i++)
      acc(1'b0, ESA_RX_SIAF + 10'(i), 8'h00, rx_exp[i]);
    acc(1'b1, ESA_RX_STAT2, 8'h02, 8'h00);
    acc(1'b0, ESA_RX_STAT2, 8'h00, 8'h00);
    acc(1'b0, ESA_TX_STAT1, 8'h00, 8'h08);
    mfw();
    txchk(7'h2a);
    acc(1'b0, ESA_S6_WORD, 8'h00, 8'h0f);
    acc(1'b0, ESA_RX_STAT7, 8'h00, 8'h02);
    ichk(1'b0);
    acc(1'b1, ESA_RX_STAT7, 8'hff, 8'h00);
    ichk(1'b1);
    acc(1'b1, ESA_TX_SRC, 8'h00, 8'h00);
    acc(1'b1, ESA_MON_SEL, 8'h01, 8'h00);
    acc(1'b1, ESA_RX_MASK7, 8'h01, 8'h00);
    line_bits.sa <= 5'h17;
    mfw();
    txchk({dflt.si, dflt.ra, dflt.sa});
    acc(1'b0, ESA_SA_LIVE, 8'h00, 8'h17);
    acc(1'b0, ESA_RX_STAT7, 8'h00, 8'h00);
    line_bits.sa <= 5'h16;
    mfw();
    acc(1'b0, ESA_RX_STAT7, 8'h00, 8'h01);
    ichk(1'b0);
    acc(1'b1, ESA_RX_STAT7, 8'h00, 8'h00);
    acc(1'b0, ESA_RX_STAT7, 8'h00, 8'h01);
    acc(1'b1, ESA_RX_STAT7, 8'h01, 8'h00);
    ichk(1'b1);
    acc(1'b1, ESA_RX_MASK7, 8'h00, 8'h00);
    line_bits.sa <= 5'h15;
    mfw();
    acc(1'b0, ESA_RX_STAT7, 8'h00, 8'h01);
    ichk(1'b1);
    conclude();
  end
endmodule
`default_nettype wire
